//--- shared/ptu_consts.svh
`ifndef PTU_CONSTS_SVH
`define PTU_CONSTS_SVH
// controller clock rate in hertz, also the accumulator modulus
`define PTU_CLK_HZ 26'h1312D00
// highest legal run frequency in hertz
`define PTU_FREQ_MAX 32'sh000186A0
// floor on the ramp rate so a ramp never stalls at zero
`define PTU_MIN_HZ 17'h00064
// fault codes
`define PTU_ERR_NONE 16'h0000
`define PTU_ERR_FREQ 16'h0001
`define PTU_ERR_HALT 16'h0002
`define PTU_ERR_TOTAL 16'h0003
`define PTU_ERR_OUTSEL 16'h0004
// status word out of reset: idle only
`define PTU_STAT_RESET 8'h80
// legal output select codes
`define PTU_SEL_FIRST 3'h2
`define PTU_SEL_LAST 3'h4
`endif

//--- shared/ptu_pkg.sv
`default_nettype none
package ptu_pkg;
    // unit state
    typedef enum logic [2:0] {
        PTU_IDLE, PTU_ACCEL, PTU_RUN, PTU_DECEL, PTU_DONE, PTU_FAULT
    } ptu_state_t;
    // status flags seen by the control program
    typedef struct packed {
        logic idleFlag;
        logic faultFlag;
        logic normalOpFlag;
        logic rungActiveFlag;
        logic doneFlag;
        logic accelFlag;
        logic cruiseFlag;
        logic decelFlag;
    } ptu_status_t;
endpackage : ptu_pkg
`default_nettype wire

//--- rtl/ptu_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptu_consts.svh"
module ptu_core #(
    parameter int RAMP_LOG2 = 6 // ramp length is 2**RAMP_LOG2 pulses
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rungIn,
    input wire logic ramp_shape_sel,
    input wire logic abrupt_halt,
    input wire logic signed [31:0] run_frequency,
    input wire logic signed [31:0] pulse_total,
    input wire logic [2:0] outSelect,
    output var ptu_pkg::ptu_status_t status,
    output logic [15:0] fault_code,
    output logic [31:0] measured_rate,
    output logic [31:0] pulsesProduced,
    output logic [2:0] pulseOuts
);
    import ptu_pkg::*;

    // the rate products below assume a modest ramp length
    generate
        if (RAMP_LOG2 < 1 || RAMP_LOG2 > 12) begin : g_bad_ramp
            $error("ptu_core: RAMP_LOG2 must lie in 1..12");
        end
    endgenerate

    localparam logic [31:0] RAMP_N = 32'h1 << RAMP_LOG2;
    localparam logic [31:0] RAMP_HALF = RAMP_N >> 1;

    ptu_state_t stateReg, stateNext; // unit state
    logic [31:0] cntReg, cntNext; // completed pulses
    logic [25:0] accReg, accNext; // phase accumulator
    logic lvlReg, lvlNext; // pulse level
    logic [15:0] codeReg, codeNext; // last fault code
    ptu_status_t statReg, statNext; // registered flags
    logic [31:0] rateReg, rateNext; // reported rate
    logic [2:0] outReg, outNext; // pin drive

    // configuration checks
    logic freqBad;
    logic totalBad;
    logic selBad;
    assign freqBad = (run_frequency < 32'sh0) ||
                     (run_frequency > `PTU_FREQ_MAX);
    assign totalBad = pulse_total < 32'sh0;
    assign selBad = (outSelect < `PTU_SEL_FIRST) ||
                    (outSelect > `PTU_SEL_LAST);

    // remaining pulses of the profile
    logic [31:0] remain;
    assign remain = pulse_total - cntReg;

    // ramp index and profile rate for the present count
    logic [31:0] idx;
    logic [63:0] runF;
    logic [63:0] prod;
    logic [63:0] rampRate;
    logic [16:0] rate;
    logic [16:0] floorHz;
    always_comb begin
        idx = RAMP_N;
        prod = 64'h0;
        rampRate = 64'h0;
        runF = {47'h0, run_frequency[16:0]};
        if (stateReg == PTU_ACCEL) begin
            // the pulse under way counts from one, so the ramp never
            // starts at zero rate and crawls along on the floor
            idx = cntReg + 32'h1;
        end else if (stateReg == PTU_DECEL) begin
            idx = remain;
        end
        // clip so a long profile never overshoots the run rate
        if (idx > RAMP_N) begin
            idx = RAMP_N;
        end
        if (!ramp_shape_sel) begin
            // straight line in pulse index
            prod = runF * {32'h0, idx};
            rampRate = prod >> RAMP_LOG2;
        end else if (idx < RAMP_HALF) begin
            // lower half of the S: quadratic rise
            prod = runF * {32'h0, idx} * {32'h0, idx};
            rampRate = prod >> (2 * RAMP_LOG2 - 1);
        end else begin
            // upper half mirrors the lower one
            prod = runF * {32'h0, RAMP_N - idx} * {32'h0, RAMP_N - idx};
            rampRate = runF - (prod >> (2 * RAMP_LOG2 - 1));
        end
        // a zero start rate would never produce the first edge
        floorHz = (run_frequency[16:0] < `PTU_MIN_HZ) ?
                  run_frequency[16:0] : `PTU_MIN_HZ;
        rate = rampRate[16:0];
        if (rate < floorHz) begin
            rate = floorHz;
        end
    end

    // accumulator step: two level changes per pulse
    logic [25:0] accSum;
    logic toggle;
    assign accSum = accReg + {8'h0, rate, 1'b0};
    assign toggle = accSum >= `PTU_CLK_HZ;

    // main sequencer next state
    logic [31:0] remainNext;
    always_comb begin
        stateNext = stateReg;
        cntNext = cntReg;
        accNext = accReg;
        lvlNext = lvlReg;
        codeNext = codeReg;
        remainNext = 32'h0;
        if (abrupt_halt) begin
            // halt wins over everything, in any state
            stateNext = PTU_FAULT;
            lvlNext = 1'b0;
            accNext = 26'h0;
            codeNext = `PTU_ERR_HALT;
        end else begin
            unique case (stateReg)
                PTU_IDLE: begin
                    lvlNext = 1'b0;
                    accNext = 26'h0;
                    // a start is only taken here
                    if (rungIn) begin
                        cntNext = 32'h0;
                        codeNext = `PTU_ERR_NONE;
                        if (freqBad) begin
                            stateNext = PTU_FAULT;
                            codeNext = `PTU_ERR_FREQ;
                        end else if (totalBad) begin
                            stateNext = PTU_FAULT;
                            codeNext = `PTU_ERR_TOTAL;
                        end else if (selBad) begin
                            stateNext = PTU_FAULT;
                            codeNext = `PTU_ERR_OUTSEL;
                        end else if (pulse_total == 32'sh0) begin
                            stateNext = PTU_DONE;
                        end else begin
                            stateNext = PTU_ACCEL;
                        end
                    end
                end
                PTU_ACCEL, PTU_RUN, PTU_DECEL: begin
                    if (freqBad) begin
                        // a bad rate mid profile also faults
                        stateNext = PTU_FAULT;
                        codeNext = `PTU_ERR_FREQ;
                        lvlNext = 1'b0;
                    end else begin
                        // average rate is exact; edges jitter by a cycle
                        accNext = toggle ? accSum - `PTU_CLK_HZ : accSum;
                        if (toggle) begin
                            lvlNext = !lvlReg;
                            if (lvlReg) begin
                                cntNext = cntReg + 32'h1;
                            end
                        end
                        remainNext = pulse_total - cntNext;
                        // phase follows the count, not the time
                        if (cntNext >= pulse_total) begin
                            stateNext = PTU_DONE;
                            lvlNext = 1'b0;
                        end else if (remainNext <= RAMP_N &&
                                     remainNext <= cntNext) begin
                            stateNext = PTU_DECEL;
                        end else if (cntNext < RAMP_N) begin
                            stateNext = PTU_ACCEL;
                        end else begin
                            stateNext = PTU_RUN;
                        end
                    end
                end
                PTU_DONE: begin
                    lvlNext = 1'b0;
                    // held until the rung is seen false once
                    if (!rungIn) begin
                        stateNext = PTU_IDLE;
                    end
                end
                PTU_FAULT: begin
                    lvlNext = 1'b0;
                    // the fault clears once halt and rung are low
                    if (!rungIn) begin
                        stateNext = PTU_IDLE;
                    end
                end
            endcase
        end
    end

    // flags and outputs follow the next state so they line up with it
    logic busyNext;
    always_comb begin
        busyNext = (stateNext == PTU_ACCEL) || (stateNext == PTU_RUN) ||
                   (stateNext == PTU_DECEL);
        statNext.idleFlag = stateNext == PTU_IDLE;
        statNext.faultFlag = stateNext == PTU_FAULT;
        statNext.normalOpFlag = busyNext || stateNext == PTU_DONE;
        statNext.rungActiveFlag = rungIn && busyNext;
        statNext.doneFlag = stateNext == PTU_DONE;
        statNext.accelFlag = stateNext == PTU_ACCEL;
        statNext.cruiseFlag = stateNext == PTU_RUN;
        statNext.decelFlag = stateNext == PTU_DECEL;
        rateNext = 32'h0;
        if (stateNext == PTU_RUN) begin
            // run phase reports the requested rate, in step with cruiseFlag
            rateNext = {15'h0, run_frequency[16:0]};
        end else if (busyNext) begin
            rateNext = {15'h0, rate};
        end
        // route the level to the selected pin only
        outNext = 3'h0;
        if (lvlNext && !selBad) begin
            outNext = 3'h1 << (outSelect - `PTU_SEL_FIRST);
        end
    end

    // state registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateReg <= PTU_IDLE;
            cntReg <= 32'h0;
            accReg <= 26'h0;
            lvlReg <= 1'b0;
            codeReg <= `PTU_ERR_NONE;
            statReg <= `PTU_STAT_RESET;
            rateReg <= 32'h0;
            outReg <= 3'h0;
        end else begin
            stateReg <= stateNext;
            cntReg <= cntNext;
            accReg <= accNext;
            lvlReg <= lvlNext;
            codeReg <= codeNext;
            statReg <= statNext;
            rateReg <= rateNext;
            outReg <= outNext;
        end
    end

    assign status = statReg;
    assign fault_code = codeReg;
    assign measured_rate = rateReg;
    assign pulsesProduced = cntReg;
    assign pulseOuts = outReg;

    // checks on the sequencer
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence sStart;
        stateReg == PTU_IDLE && rungIn && !abrupt_halt && !freqBad &&
        !totalBad && !selBad && pulse_total > 32'sh0;
    endsequence
    sequence sAccelUp;
        status.accelFlag && status.rungActiveFlag && !status.idleFlag;
    endsequence

    a_halt_output: assert property (abrupt_halt |=> pulseOuts == 3'h0 &&
        status.faultFlag) else $error("halt did not stop pulses");
    a_halt_code: assert property (abrupt_halt |=>
        fault_code == `PTU_ERR_HALT && !status.normalOpFlag)
        else $error("halt code missing");
    a_fault_state: assert property (status.faultFlag ==
        (stateReg == PTU_FAULT)) else $error("fault flag wrong");
    a_idle_clean: assert property (status.idleFlag |->
        !status.faultFlag && !status.normalOpFlag && pulseOuts == 3'h0)
        else $error("idle while busy");
    a_normal_set: assert property (status.normalOpFlag ==
        (stateReg inside {PTU_ACCEL, PTU_RUN, PTU_DECEL, PTU_DONE}))
        else $error("normal flag wrong");
    a_freq_range: assert property (stateReg == PTU_IDLE && rungIn &&
        !abrupt_halt && freqBad |=> status.faultFlag &&
        fault_code == `PTU_ERR_FREQ) else $error("bad rate taken");
    a_one_phase: assert property ($onehot0({status.accelFlag,
        status.cruiseFlag, status.decelFlag}))
        else $error("two phases at once");
    a_done_count: assert property ($rose(status.doneFlag) |->
        pulsesProduced == pulse_total || pulse_total == 32'sh0)
        else $error("done at wrong count");
    a_rung_drop: assert property (!rungIn |=> !status.rungActiveFlag)
        else $error("active flag kept");
    a_done_clear: assert property (status.doneFlag && !rungIn &&
        !abrupt_halt |=> !status.doneFlag && status.idleFlag)
        else $error("done not cleared");
    a_start_accel: assert property (sStart |=> sAccelUp)
        else $error("start not taken");
    a_run_rate: assert property (status.cruiseFlag |->
        measured_rate == {15'h0, run_frequency[16:0]})
        else $error("run rate wrong");
    a_pin_select: assert property ($onehot0(pulseOuts) &&
        (pulseOuts == 3'h0 || !$past(selBad)))
        else $error("pin select wrong");
    a_rate_limit: assert property (measured_rate <= $past(run_frequency))
        else $error("rate above request");
    a_start_idle: assert property ($rose(status.accelFlag) |->
        $past(status.idleFlag))
        else $error("start not from idle");
endmodule : ptu_core
`default_nettype wire

//--- tb/ptu_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
// drive side of the pulse outputs: one step counter per pin
module ptu_drive_model (
    input wire logic core_clk,
    input wire logic [2:0] pulseIn, // pin levels from the unit
    input wire logic clearCounts, // zeroes all counters
    output logic [2:0][31:0] steps // rising edges seen per pin
);
    logic [2:0] lastIn; // pin levels one cycle back
    // a drive steps on each rising edge of its input
    always_ff @(posedge core_clk) begin
        lastIn <= pulseIn;
        for (int i = 0; i < 3; i++) begin
            if (clearCounts) begin
                steps[i] <= '0;
            end else if (pulseIn[i] && !lastIn[i]) begin
                steps[i] <= steps[i] + 32'h1;
            end
        end
    end
endmodule : ptu_drive_model
`default_nettype wire

//--- tb/tb_ptu_core.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ptu_core;
    import ptu_pkg::*;
    logic core_clk = 0;
    logic rst = 1;
    logic rungIn = 0;
    logic rampSel = 0;
    logic haltIn = 0;
    logic signed [31:0] runFreq = 0;
    logic signed [31:0] pulseTot = 0;
    logic [2:0] outSel = 3'h2;
    logic clr = 1; // clears drive counts and run monitors
    ptu_status_t status;
    logic [15:0] fault_code;
    logic [31:0] measured_rate, pulsesProduced, maxRate, busyCycles;
    logic [2:0] pulseOuts;
    logic [2:0][31:0] steps;
    logic [7:0] seenBits; // every status bit seen during a run
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int durTrap;
    always #25 core_clk = ~core_clk;
    ptu_core #(.RAMP_LOG2(2)) i_ptu_core (.core_clk(core_clk), .rst(rst),
        .rungIn(rungIn), .ramp_shape_sel(rampSel), .abrupt_halt(haltIn),
        .run_frequency(runFreq), .pulse_total(pulseTot),
        .outSelect(outSel), .status(status), .fault_code(fault_code),
        .measured_rate(measured_rate), .pulsesProduced(pulsesProduced),
        .pulseOuts(pulseOuts));
    ptu_drive_model i_ptu_drive_model (.core_clk(core_clk),
        .pulseIn(pulseOuts), .clearCounts(clr), .steps(steps));
    task automatic check_stat(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_stat
    task automatic check_num(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    // sample 1 ns after the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // bounded wait for a flag, so a stuck unit cannot hang the run
    task automatic wait_flag(input bit done, input int limit);
        for (int i = 0; i < limit; i++) begin
            if (done ? status.doneFlag === 1'b1 : status.idleFlag === 1'b1)
                return;
            tick(1);
        end
        fails++;
        $display("ERROR flag wait expected 1 seen 0");
    endtask : wait_flag
    // mode 0 plain, 1 rung dropped mid-profile, 2 hard stop mid-profile
    task automatic run_job(input logic [2:0] sel, input logic shp,
            input logic signed [31:0] f, n, input int mode,
            input logic [7:0] expSt, input logic [15:0] code);
        logic [31:0] snap;
        wait_flag(0, 50);
        @(posedge core_clk);
        clr <= 1;
        outSel <= sel;
        rampSel <= shp;
        runFreq <= f;
        pulseTot <= n;
        @(posedge core_clk);
        clr <= 0;
        rungIn <= 1;
        tick(1);
        check_stat("start status", expSt, status);
        check_num("fault code", {16'h0, code}, {16'h0, fault_code});
        if (mode == 2) begin
            // halt in the middle of the first high half-pulse
            tick(1000);
            check_num("pin at halt", 32'h1, {29'h0, pulseOuts});
            @(posedge core_clk);
            haltIn <= 1;
            tick(2);
            check_stat("halted", 8'h40, status & 8'hE0);
            check_num("halt code", 32'h2, {16'h0, fault_code});
            check_num("pins after halt", 32'h0, {29'h0, pulseOuts});
            snap = steps[sel - 3'h2];
            // long enough for a runaway unit to raise the pin again
            tick(1000);
            check_num("steps after halt", snap, steps[sel - 3'h2]);
        end else if (expSt == 8'h34) begin
            if (mode == 1) begin
                tick(300);
                @(posedge core_clk);
                rungIn <= 0;
                tick(1);
                check_stat("rung dropped", 8'h20, status & 8'h30);
            end
            wait_flag(1, 10000);
            check_stat("done status", 8'h28, status);
            check_num("pulses produced", n, pulsesProduced);
            check_num("steps at drive", n, steps[sel - 3'h2]);
            check_num("steps all pins", n, steps[0] + steps[1] + steps[2]);
            check_num("peak rate", f, maxRate);
            check_stat("phases seen", 8'h07, seenBits & 8'h07);
        end
        @(posedge core_clk);
        haltIn <= 0;
        rungIn <= 0;
        tick(3);
        check_stat("back to idle", 8'h80, status);
        check_num("idle rate", 32'h0, measured_rate);
    endtask : run_job
    // per-run monitors, restarted by clr
    always @(posedge core_clk) begin
        if (clr) begin
            maxRate <= 0;
            seenBits <= 0;
            busyCycles <= 0;
        end else begin
            if (measured_rate > maxRate) maxRate <= measured_rate;
            seenBits <= seenBits | status;
            if (!status.idleFlag) busyCycles <= busyCycles + 1;
        end
    end
    // flag relations that must hold on every cycle
    always @(negedge core_clk) begin
        if (!rst) begin
            check_stat("idle alone", 0, {7'h0, status.idleFlag
                & (status.faultFlag | status.normalOpFlag)});
            check_stat("one phase", 0, {7'h0, $countones({status.accelFlag,
                status.cruiseFlag, status.decelFlag}) > 1});
            check_stat("normal flag", {7'h0, ~status.faultFlag
                & (status.doneFlag | status.accelFlag | status.cruiseFlag
                | status.decelFlag)}, {7'h0, status.normalOpFlag});
            check_stat("pins in fault", 0,
                {5'h0, pulseOuts & {3{status.faultFlag}}});
        end
    end
    // hang guard: the whole list needs about 15000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 0;
        tick(1);
        check_stat("reset status", 8'h80, status);
        check_num("reset pins", 32'h0, {29'h0, pulseOuts});
        run_job(3'h2, 0, 100000, 10, 0, 8'h34, 0);
        durTrap = busyCycles;
        run_job(3'h3, 1, 100000, 10, 0, 8'h34, 0);
        check_num("shape alters ramp", 1, durTrap != busyCycles);
        run_job(3'h4, 0, 100000, 10, 1, 8'h34, 0);
        run_job(3'h2, 1, 100000, 10, 2, 8'h34, 0);
        run_job(3'h2, 0, 100001, 10, 0, 8'h40, 1);
        run_job(3'h2, 0, -1, 10, 0, 8'h40, 1);
        run_job(3'h3, 0, 5000, -5, 0, 8'h40, 3);
        run_job(3'h5, 0, 5000, 10, 0, 8'h40, 4);
        run_job(3'h3, 0, 5000, 0, 0, 8'h28, 0);
        @(posedge core_clk);
        haltIn <= 1;
        tick(2);
        check_stat("halt from idle", 8'h40, status);
        check_num("idle halt code", 32'h2, {16'h0, fault_code});
        @(posedge core_clk);
        haltIn <= 0;
        tick(3);
        check_stat("halt released", 8'h80, status);
        final_report();
    end
endmodule : tb_ptu_core
`default_nettype wire
